/* File: verilog/smbsp_port.sv */
/*
 * smbsp_port: smbus slave port with pointer, register access strobes,
 * one-shot trigger, bus timeout and alarm / alert response logic.
 * assumes scl_clk_i is the serial clock line used as a clock, and that
 * the register store lives outside, answering reads combinationally.
 */
// Behaviour
// - answer only to address 0x4c, or 0x4d in the alternate build
// - start is data falling while clock high; then address and direction shift in
// - acknowledge a matching address in ninth bit, else idle until next start
// - direction 0 is master write, 1 is master read
// - nine clocks per byte; device acknowledges bytes it receives
// - data changes while clock low; rising data with clock high is stop
// - direction fixed at start; switching needs new start and address
// - writes carry one or two bytes; reads return one byte
// - first written byte always loads the register pointer
// - second written byte is stored at the pointed register
// - reads return the register at the pointer left earlier
// - read and write pointer values may differ for one register
// - optional 25 ms inactivity timeout, enabled by bit 7 of 0x22
// - write to pointer 0x0f triggers one measurement, data discarded
// - open-drain alarm low while out of limits or sensor open
// - alarm and alert response only when pin set to alarm function
// - alert response read returns own address with one appended
// - lost arbitration keeps alarm for a later alert response
// - alarm released after answering, only once cause has gone
// - status read alone does not release the alarm latch
`timescale 1ns/10ps
`default_nettype none
module smbsp_port #(
    parameter bit     ALT_ADDR      = 1'b0,
    parameter longint TIMEOUT_CYCLES = smbsp_pkg::TIMEOUT_CYC
) (
    // system side
    input  wire logic       clock_i,
    input  wire logic       rst_b_i,
    // serial link, sampled on the link clock
    input  wire logic       scl_clk_i,
    input  wire logic       serial_data_line_i,
    output logic            serial_data_line_o,
    output logic            serial_data_line_oe_o,
    // register store
    output logic [7:0]      reg_ptr_o,
    output logic [7:0]      reg_wdata_o,
    output logic            reg_write_o,
    input  wire logic [7:0] reg_rdata_i,
    output logic            one_shot_o,
    // alarm
    input  wire logic       alarm_cause_i,
    input  wire logic       pin_is_alarm_i,
    output logic            alarm_n_o,
    output logic            alarm_n_oe_o
);
    // the timeout counter is 32 bits; longer counts would be truncated in the compare and fire too soon
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 64'hffffffff) begin : g_bad_timeout
        $error("timeout count out of range");
    end

    // =========================================================
    // link-side start / stop detection (scl level sampled on data edges)
    // start and stop are data edges while clock high; caught on data edges
    logic start_tog;
    logic stop_tog;
    logic scl_high_seen;
    logic link_rst_b;
    assign scl_high_seen = scl_clk_i;
    always_ff @(negedge serial_data_line_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            start_tog <= 1'b0;
        end else if (scl_high_seen) begin
            start_tog <= ~start_tog;
        end
    end
    always_ff @(posedge serial_data_line_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            stop_tog <= 1'b0;
        end else if (scl_high_seen) begin
            stop_tog <= ~stop_tog;
        end
    end

    // =========================================================
    // link state machine on scl
    typedef enum logic [4:0] {
        SMBSP_IDLE = 5'b00001,
        SMBSP_ADDR = 5'b00010,
        SMBSP_WRB  = 5'b00100,
        SMBSP_RDB  = 5'b01000,
        SMBSP_WAIT = 5'b10000
    } smbsp_state_e;
    smbsp_state_e state;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [1:0]  wr_count;
    logic        ara_xfer;
    logic        lost_arb;
    logic        start_seen_q;
    logic        stop_seen_q;
    logic        ack_drive;
    logic        data_drive_low;
    logic        wr_tog;
    logic        ptr_tog;
    logic        arsp_tog;
    logic [7:0]  link_ptr;
    logic [7:0]  link_wdata;
    logic [7:0]  rd_byte;
    logic [6:0]  own_addr;
    logic        new_start;
    logic        new_stop;
    logic        alarm_active_l1;
    logic        alarm_active_l;
    assign own_addr  = ALT_ADDR ? smbsp_pkg::OWN_ADDR_ALT : smbsp_pkg::OWN_ADDR_BASE;
    assign new_start = start_tog != start_seen_q;
    assign new_stop  = stop_tog != stop_seen_q;

    wire [7:0] shift_in   = {shift[6:0], serial_data_line_i};
    wire       addr_match = shift_in[7:1] == own_addr;
    wire       ara_match  = (shift_in[7:1] == smbsp_pkg::ALERT_RESP_ADDR) && shift_in[0]
                            && alarm_active_l;
    wire [7:0] arsp_byte  = {own_addr, 1'b1};

    always_ff @(posedge scl_clk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            state        <= SMBSP_IDLE;
            bit_cnt      <= 4'h0;
            shift        <= 8'h00;
            wr_count     <= 2'h0;
            ara_xfer     <= 1'b0;
            lost_arb     <= 1'b0;
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b0;
        end else if (new_start) begin
            start_seen_q <= start_tog;
            stop_seen_q  <= stop_tog;
            state        <= SMBSP_ADDR;
            bit_cnt      <= 4'h1;
            shift        <= {7'h00, serial_data_line_i};
            wr_count     <= 2'h0;
            ara_xfer     <= 1'b0;
            lost_arb     <= 1'b0;
        end else if (new_stop) begin
            stop_seen_q <= stop_tog;
            state       <= SMBSP_IDLE;
            bit_cnt     <= 4'h0;
        end else begin
            unique case (state)
                SMBSP_IDLE, SMBSP_WAIT: begin
                    bit_cnt <= 4'h0;
                end
                SMBSP_ADDR: begin
                    if (bit_cnt == 4'h7) begin
                        shift <= shift_in;
                        bit_cnt <= smbsp_pkg::ACK_BIT;
                        if (addr_match) begin
                            state <= shift_in[0] ? SMBSP_RDB : SMBSP_WRB;
                        end else if (ara_match) begin
                            state    <= SMBSP_RDB;
                            ara_xfer <= 1'b1;
                        end else begin
                            state <= SMBSP_WAIT;
                        end
                    end else begin
                        shift   <= shift_in;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                SMBSP_WRB: begin
                    if (bit_cnt == smbsp_pkg::ACK_BIT) begin
                        bit_cnt <= 4'h0;
                    end else if (bit_cnt == 4'h7) begin
                        bit_cnt <= smbsp_pkg::ACK_BIT;
                        if (wr_count == 2'h0) begin
                            wr_count <= 2'h1;
                        end else if (wr_count == 2'h1) begin
                            wr_count <= 2'h2;
                        end else begin
                            state <= SMBSP_WAIT;
                        end
                    end else begin
                        shift   <= shift_in;
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                SMBSP_RDB: begin
                    if (bit_cnt == smbsp_pkg::ACK_BIT) begin
                        bit_cnt <= 4'h0;
                    end else if (bit_cnt == 4'h7) begin
                        bit_cnt <= smbsp_pkg::ACK_BIT;
                        state   <= SMBSP_WAIT;
                    end else begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    // released one but line low: another device won
                    if (bit_cnt != smbsp_pkg::ACK_BIT && rd_byte[3'(7 - bit_cnt)]
                        && !serial_data_line_i) begin
                        lost_arb <= 1'b1;
                    end
                end
                default: begin
                    state <= SMBSP_IDLE;
                end
            endcase
        end
    end

    // =========================================================
    // byte hand-off toggles
    // only the full reset clears these: a timeout reset would fake an event
    wire byte_end  = !new_start && !new_stop && bit_cnt == 4'h7;
    wire take_ptr  = byte_end && state == SMBSP_WRB && wr_count == 2'h0;
    wire take_data = byte_end && state == SMBSP_WRB && wr_count == 2'h1;
    wire take_arsp = byte_end && state == SMBSP_RDB && ara_xfer && !lost_arb;
    always_ff @(posedge scl_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_tog    <= 1'b0;
            wr_tog     <= 1'b0;
            arsp_tog   <= 1'b0;
            link_ptr   <= smbsp_pkg::PTR_RESET;
            link_wdata <= 8'h00;
        end else begin
            if (take_ptr) begin
                link_ptr <= shift_in;
                ptr_tog  <= ~ptr_tog;
            end
            if (take_data) begin
                link_wdata <= shift_in;
                wr_tog     <= ~wr_tog;
            end
            if (take_arsp) begin
                arsp_tog <= ~arsp_tog;
            end
        end
    end

    // drive on falling scl so data is stable through clock high
    assign rd_byte = ara_xfer ? arsp_byte : reg_rdata_i;
    always_ff @(negedge scl_clk_i or negedge link_rst_b) begin
        if (!link_rst_b) begin
            ack_drive      <= 1'b0;
            data_drive_low <= 1'b0;
        end else begin
            ack_drive <= (bit_cnt == smbsp_pkg::ACK_BIT)
                         && (state == SMBSP_WRB || state == SMBSP_RDB)
                         && !(state == SMBSP_RDB && !shift[0] && !ara_xfer);
            data_drive_low <= state == SMBSP_RDB && bit_cnt != smbsp_pkg::ACK_BIT
                              && !lost_arb && !rd_byte[3'(7 - bit_cnt)];
        end
    end
    assign serial_data_line_o    = 1'b0;
    assign serial_data_line_oe_o = ack_drive | data_drive_low;

    // =========================================================
    // crossings into the system clock
    logic [2:0] ptr_sync;
    logic [2:0] wr_sync;
    logic [2:0] arsp_sync;
    logic [1:0] scl_sync;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ptr_sync  <= 3'h0;
            wr_sync   <= 3'h0;
            arsp_sync <= 3'h0;
            scl_sync  <= 2'h0;
        end else begin
            ptr_sync  <= {ptr_sync[1:0], ptr_tog};
            wr_sync   <= {wr_sync[1:0], wr_tog};
            arsp_sync <= {arsp_sync[1:0], arsp_tog};
            scl_sync  <= {scl_sync[0], scl_clk_i};
        end
    end
    wire ptr_evt  = ptr_sync[2] ^ ptr_sync[1];
    wire wr_evt   = wr_sync[2] ^ wr_sync[1];
    wire arsp_evt = arsp_sync[2] ^ arsp_sync[1];

    // =========================================================
    // pointer, write strobe, one-shot and timeout enable
    logic       to_enable;
    logic [7:0] sys_ptr;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sys_ptr     <= smbsp_pkg::PTR_RESET;
            reg_wdata_o <= 8'h00;
            reg_write_o <= 1'b0;
            one_shot_o  <= 1'b0;
            to_enable   <= 1'b0;
        end else begin
            reg_write_o <= 1'b0;
            one_shot_o  <= 1'b0;
            if (ptr_evt) begin
                sys_ptr <= link_ptr;
            end
            if (wr_evt) begin
                if (sys_ptr == smbsp_pkg::PTR_ONE_SHOT) begin
                    one_shot_o <= 1'b1;
                end else begin
                    reg_wdata_o <= link_wdata;
                    reg_write_o <= 1'b1;
                end
                if (sys_ptr == smbsp_pkg::PTR_CONSEC_ALR) begin
                    to_enable <= link_wdata[smbsp_pkg::TIMEOUT_EN_BIT];
                end
            end
        end
    end
    assign reg_ptr_o = sys_ptr;

    // =========================================================
    // bus timeout: clock held low too long resets the link side
    logic [31:0] to_cnt;
    logic        to_fire;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            to_cnt  <= 32'h0;
            to_fire <= 1'b0;
        end else if (!to_enable || scl_sync[1] || to_fire) begin
            to_cnt  <= 32'h0;
            to_fire <= 1'b0;
        end else if (to_cnt >= 32'(TIMEOUT_CYCLES - 1)) begin
            to_fire <= 1'b1;
        end else begin
            to_cnt <= to_cnt + 32'h1;
        end
    end
    // reset pulse lasts one system cycle; async into link logic
    assign link_rst_b = rst_b_i & ~to_fire;

    // =========================================================
    // alarm latch
    logic alarm_latch;
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_latch <= 1'b0;
        end else if (alarm_cause_i) begin
            alarm_latch <= 1'b1;
        end else if (arsp_evt) begin
            alarm_latch <= 1'b0;
        end
    end
    // level into the link domain through two flops
    always_ff @(posedge scl_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alarm_active_l1 <= 1'b0;
            alarm_active_l  <= 1'b0;
        end else begin
            alarm_active_l1 <= alarm_latch & pin_is_alarm_i;
            alarm_active_l  <= alarm_active_l1;
        end
    end
    assign alarm_n_o    = 1'b0;
    assign alarm_n_oe_o = alarm_latch & pin_is_alarm_i;
endmodule
`default_nettype wire

/* File: verilog/smbsp_pkg.sv */
/*
 * smbsp_pkg: constants shared by the smbus slave alert port.
 * assumes a 200 MHz system clock; the serial link runs on its own clock.
 */
package smbsp_pkg;
    // =========================================================
    // addressing
    localparam logic [6:0] OWN_ADDR_BASE = 7'h4c;
    localparam logic [6:0] OWN_ADDR_ALT  = 7'h4d;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
    // =========================================================
    // pointer values with side effects
    localparam logic [7:0] PTR_ONE_SHOT   = 8'h0f;
    localparam logic [7:0] PTR_CONSEC_ALR = 8'h22;
    localparam int         TIMEOUT_EN_BIT = 7;
    localparam logic [7:0] PTR_RESET      = 8'h00;
    // =========================================================
    // timing
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int TIMEOUT_MS      = 25;
    localparam longint TIMEOUT_CYC = (longint'(TIMEOUT_MS) * 1000000000) / CLK_PERIOD_PS;
    localparam int BIT_CNT_W       = 4;
    localparam logic [3:0] ACK_BIT = 4'h8;
endpackage

/* File: testbench/smbsp_port_sva.sv */
/* smbsp_port_sva: port checker for smbsp_port.
   assumes it is bound to every smbsp_port instance. */
`timescale 1ns/10ps
`default_nettype none
module smbsp_port_sva (
    // system side
    input wire logic       clock_i,
    input wire logic       rst_b_i,
    // serial link
    input wire logic       scl_clk_i,
    input wire logic       serial_data_line_o,
    input wire logic       serial_data_line_oe_o,
    // register store
    input wire logic [7:0] reg_ptr_o,
    input wire logic       reg_write_o,
    input wire logic       one_shot_o,
    // alarm
    input wire logic       alarm_cause_i,
    input wire logic       pin_is_alarm_i,
    input wire logic       alarm_n_o,
    input wire logic       alarm_n_oe_o
);
    // ========
    // checks
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    a_data_open_drain: assert property (serial_data_line_o == 1'b0)
        else $error("data line driven high");
    a_alarm_open_drain: assert property (alarm_n_o == 1'b0)
        else $error("alarm line driven high");
    a_data_stable_high: assert property (scl_clk_i && $past(scl_clk_i) |->
        $stable(serial_data_line_oe_o)) else $error("data moved while clock high");
    a_store_one_pulse: assert property (reg_write_o |=> !reg_write_o)
        else $error("store strobe too long");
    a_shot_not_stored: assert property (one_shot_o |-> !reg_write_o ##1 !one_shot_o)
        else $error("one shot data stored");
    a_ptr_apart: assert property ($changed(reg_ptr_o) |-> !reg_write_o && !one_shot_o)
        else $error("pointer moved with store");
    a_alarm_sets: assert property (pin_is_alarm_i && alarm_cause_i |->
        ##[0:4] alarm_n_oe_o) else $error("alarm not raised");
    a_alarm_kept: assert property (alarm_n_oe_o && alarm_cause_i && pin_is_alarm_i
        ##1 pin_is_alarm_i |-> alarm_n_oe_o) else $error("alarm dropped early");
    a_alarm_gated: assert property (!pin_is_alarm_i [*3] |-> !alarm_n_oe_o)
        else $error("alarm while pin not alarm");
    c_store: cover property (reg_write_o);
    c_shot: cover property (one_shot_o);
    c_release: cover property ($fell(alarm_n_oe_o));
endmodule
bind smbsp_port smbsp_port_sva i_sva (.clock_i, .rst_b_i, .scl_clk_i, .serial_data_line_o,
    .serial_data_line_oe_o, .reg_ptr_o, .reg_write_o, .one_shot_o, .alarm_cause_i,
    .pin_is_alarm_i, .alarm_n_o, .alarm_n_oe_o);
`default_nettype wire

/* File: testbench/smbsp_host_model.sv */
/* smbsp_host_model: behavioural smbus master, 32 ns clock within frames.
   assumes the bench resolves the data wire with a pull-up. */
`timescale 1ns/10ps
`default_nettype none
module smbsp_host_model (
    // serial link
    output logic      scl_o,
    output logic      sda_oe_o,
    input  wire logic sda_i
);
    // ========
    // bus phases; clock stands high between frames
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // also serves as repeated start
    task automatic start();
        sda_oe_o = 1'b0;
        #8;
        scl_o = 1'b1;
        #8;
        sda_oe_o = 1'b1;
        #8;
        scl_o = 1'b0;
        #8;
    endtask
    task automatic stop();
        sda_oe_o = 1'b1;
        #8;
        scl_o = 1'b1;
        #8;
        sda_oe_o = 1'b0;
        #16;
    endtask
    task automatic bit_io(input logic b, output logic seen);
        sda_oe_o = !b;
        #8;
        scl_o = 1'b1;
        #8;
        seen = sda_i;
        #8;
        scl_o = 1'b0;
        #8;
    endtask
    // ninth bit released: write waits for ack, one-byte read ends in nack
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, a);
        ack = !a;
    endtask
endmodule
`default_nettype wire

/* File: testbench/smbus_slave_alert_port_tb_top.sv */
/* smbus_slave_alert_port_tb_top: self-checking bench for smbsp_port.
   assumes host model and checker compiled first. */
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_alert_port_tb_top;
    // ========
    // signals
    logic       clock_i = 1'b0;
    logic       rst_b_i;
    logic       alarm_cause_i = 1'b0;
    logic       pin_is_alarm_i = 1'b1;
    logic [7:0] rdata = 8'h00;
    logic [7:0] wr_ptr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] ptr, wdata;
    logic       scl, host_oe, dut_oe, alarm_oe, wr_stb, os_stb;
    int         n_wr = 0, n_os = 0, bad_count = 0, num_checks = 0, cyc = 0;
    wire        sda = !(host_oe | dut_oe);
    wire        alarm_line = !alarm_oe;
    smbsp_host_model i_host (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));
    // short timeout keeps the run brief
    smbsp_port #(.TIMEOUT_CYCLES(50)) i_dut (.clock_i, .rst_b_i, .scl_clk_i(scl),
        .serial_data_line_i(sda), .serial_data_line_o(), .serial_data_line_oe_o(dut_oe),
        .reg_ptr_o(ptr), .reg_wdata_o(wdata), .reg_write_o(wr_stb), .reg_rdata_i(rdata),
        .one_shot_o(os_stb), .alarm_cause_i, .pin_is_alarm_i, .alarm_n_o(),
        .alarm_n_oe_o(alarm_oe));
    always #2.5 clock_i = !clock_i;
    always @(posedge clock_i) begin
        rdata <= ptr ^ 8'h3c;
        cyc <= cyc + 1;
        if (wr_stb === 1'b1) begin
            n_wr <= n_wr + 1;
            wr_ptr <= ptr;
            wr_data <= wdata;
        end
        if (os_stb === 1'b1) begin
            n_os <= n_os + 1;
        end
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end
    // ========
    // helpers
    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic set_alarm(input logic c, input logic p);
        @(posedge clock_i);
        alarm_cause_i <= c;
        pin_is_alarm_i <= p;
        #40.5;
    endtask
    task automatic put(input logic [7:0] tx, input logic exp_ack);
        logic [7:0] rx;
        logic       ack;
        i_host.xfer(tx, rx, ack);
        chk("ack", {7'h0, exp_ack}, {7'h0, ack});
    endtask
    task automatic get(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] rx;
        logic       ack;
        i_host.start();
        put({a, 1'b1}, 1'b1);
        i_host.xfer(8'hff, rx, ack);
        i_host.stop();
        chk("rdata", exp, rx);
    endtask
    task automatic hold_test(input logic exp);
        logic b;
        i_host.start();
        for (int i = 7; i >= 0; i--) begin
            i_host.bit_io(i == 7 || i == 4 || i == 3, b);
        end
        #400;
        chk("held ack", {7'h0, exp}, {7'h0, dut_oe});
        i_host.bit_io(1'b1, b);
        i_host.stop();
    endtask
    // ========
    // scenarios
    task automatic s_write();
        i_host.start();
        put(8'h98, 1'b1);
        put(8'h09, 1'b1);
        put(8'ha5, 1'b1);
        i_host.stop();
        #40;
        chk("wr_ptr", 8'h09, wr_ptr);
        chk("wr_data", 8'ha5, wr_data);
    endtask
    task automatic s_read();
        int n0;
        n0 = n_wr;
        i_host.start();
        put(8'h98, 1'b1);
        put(8'h05, 1'b1);
        get(7'h4c, 8'h39);
        get(7'h4c, 8'h39);
        chk("stores", 8'(n0), 8'(n_wr));
    endtask
    task automatic s_refuse();
        i_host.start();
        put(8'h9a, 1'b0);
        put(8'h22, 1'b0);
        i_host.stop();
        chk("ptr", 8'h05, ptr);
        i_host.start();
        put(8'h98, 1'b1);
        put(8'h13, 1'b1);
        put(8'h44, 1'b1);
        put(8'h55, 1'b0);
        i_host.stop();
        #40;
        chk("wr_ptr", 8'h13, wr_ptr);
        chk("wr_data", 8'h44, wr_data);
    endtask
    task automatic s_oneshot();
        int n0;
        n0 = n_wr;
        i_host.start();
        put(8'h98, 1'b1);
        put(8'h0f, 1'b1);
        put(8'h77, 1'b1);
        i_host.stop();
        #40;
        chk("one_shot", 8'h01, 8'(n_os));
        chk("stores", 8'(n0), 8'(n_wr));
        #320;
    endtask
    task automatic s_alert();
        logic [7:0] rx;
        logic       ack;
        set_alarm(1'b1, 1'b1);
        chk("alarm", 8'h00, {7'h0, alarm_line});
        get(7'h0c, 8'h99);
        chk("alarm", 8'h00, {7'h0, alarm_line});
        set_alarm(1'b0, 1'b1);
        get(7'h4c, 8'h33);
        chk("alarm", 8'h00, {7'h0, alarm_line});
        // host stands in for a lower-addressed device answering too
        i_host.start();
        put(8'h19, 1'b1);
        i_host.xfer(8'h97, rx, ack);
        i_host.stop();
        #40;
        chk("arb rdata", 8'h97, rx);
        chk("alarm", 8'h00, {7'h0, alarm_line});
        get(7'h0c, 8'h99);
        #40;
        chk("alarm", 8'h01, {7'h0, alarm_line});
        set_alarm(1'b1, 1'b0);
        chk("alarm", 8'h01, {7'h0, alarm_line});
        i_host.start();
        put(8'h19, 1'b0);
        i_host.stop();
        set_alarm(1'b0, 1'b1);
    endtask
    task automatic s_timeout();
        hold_test(1'b1);
        i_host.start();
        put(8'h98, 1'b1);
        put(8'h22, 1'b1);
        put(8'h80, 1'b1);
        i_host.stop();
        hold_test(1'b0);
        s_write();
    endtask
    initial begin
        rst_b_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rst_b_i <= 1'b1;
        #0.5;
        s_write();
        s_read();
        s_refuse();
        s_oneshot();
        s_alert();
        s_timeout();
        final_report();
    end
endmodule
`default_nettype wire
